// ---- verilog/pcu_array.sv ----
// Counter array top: two counters, six units, flags and register port.
// Assumes a master with one-cycle strobes and read data taken next cycle.
`timescale 1ns/1ps
`default_nettype none
module pcu_array #(
  parameter int UNITS = pcu_pkg::UNITS // Number of units
) (
  input wire logic clk, // Core clock, 50 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic [7:0] addr, // Register index
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, one cycle later
  input wire logic [UNITS-1:0] pin_in, // Unit pin levels
  output logic [UNITS-1:0] pin_out, // Unit pin drive levels
  output logic [UNITS-1:0] pin_oe, // Unit pin drive enables
  output logic irq // Shared interrupt request
);
  logic [7:0] ctl0;
  logic [7:0] ctl1;
  logic [7:0] next_ctl0;
  logic [7:0] next_ctl1;
  logic [15:0] cnt0;
  logic [15:0] cnt1;
  logic [15:0] next_cnt0;
  logic [15:0] next_cnt1;
  logic roll0;
  logic roll1;
  logic next_roll0;
  logic next_roll1;
  logic [7:0] next_rdata;
  logic [7:0] mode [UNITS];
  logic [15:0] cc [UNITS];
  logic [UNITS-1:0] match_evt;
  logic [UNITS-1:0] cap_evt;
  logic [7:0] flags;
  logic [7:0] hw_set;
  logic [7:0] irq_mask;
  logic flags_wr;
  logic run0;
  logic run1;

  // Counter run and resolution
  always_comb
  begin
    run0 = ctl0[pcu_pkg::CTL_RUN] || ctl0[pcu_pkg::CTL_ALL_RUN];
    run1 = ctl1[pcu_pkg::CTL_RUN] || ctl0[pcu_pkg::CTL_ALL_RUN];
    next_cnt0 = cnt0;
    next_cnt1 = cnt1;
    next_roll0 = 1'b0;
    next_roll1 = 1'b0;
    if (run0)
    begin
      if (ctl0[pcu_pkg::CTL_TEN_BIT] ? (cnt0[9:0] == pcu_pkg::TEN_BIT_TOP)
        : (cnt0 == pcu_pkg::SIXTEEN_BIT_TOP))
      begin
        next_cnt0 = 16'h0000;
        next_roll0 = 1'b1;
      end
      else
      begin
        next_cnt0 = cnt0 + 16'h0001;
      end
    end
    if (run1)
    begin
      if (ctl1[pcu_pkg::CTL_TEN_BIT] ? (cnt1[9:0] == pcu_pkg::TEN_BIT_TOP)
        : (cnt1 == pcu_pkg::SIXTEEN_BIT_TOP))
      begin
        next_cnt1 = 16'h0000;
        next_roll1 = 1'b1;
      end
      else
      begin
        next_cnt1 = cnt1 + 16'h0001;
      end
    end
  end

  // Control register writes
  always_comb
  begin
    next_ctl0 = ctl0;
    next_ctl1 = ctl1;
    if (wr && addr == pcu_pkg::ADDR_CTL0)
    begin
      next_ctl0 = wdata & pcu_pkg::CTL0_MASK;
    end
    if (wr && addr == pcu_pkg::ADDR_CTL1)
    begin
      next_ctl1 = wdata & pcu_pkg::CTL1_MASK;
    end
  end

  // Counter and control registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl0 <= pcu_pkg::CTL_RESET;
      ctl1 <= pcu_pkg::CTL_RESET;
      cnt0 <= 16'h0000;
      cnt1 <= 16'h0000;
      roll0 <= 1'b0;
      roll1 <= 1'b0;
    end
    else
    begin
      ctl0 <= next_ctl0;
      ctl1 <= next_ctl1;
      cnt0 <= next_cnt0;
      cnt1 <= next_cnt1;
      roll0 <= next_roll0;
      roll1 <= next_roll1;
    end
  end

  // Per-unit mode, capture/compare storage and unit logic
  for (genvar u = 0; u < UNITS; u++)
  begin : g_unit
    logic [7:0] next_mode;
    logic [15:0] next_cc;
    logic [15:0] ucnt;
    logic uten;

    always_comb
    begin
      ucnt = (u < pcu_pkg::UNITS_PER_CNT) ? cnt0 : cnt1;
      uten = (u < pcu_pkg::UNITS_PER_CNT) ? ctl0[pcu_pkg::CTL_TEN_BIT]
        : ctl1[pcu_pkg::CTL_TEN_BIT];
      next_mode = mode[u];
      next_cc = cc[u];
      if (wr && addr == pcu_pkg::ADDR_MODE_BASE + 8'(u))
      begin
        next_mode = wdata;
      end
      if (wr && addr == pcu_pkg::ADDR_CC_BASE + 8'(2 * u))
      begin
        next_cc[7:0] = wdata;
      end
      if (wr && addr == pcu_pkg::ADDR_CC_BASE + 8'(2 * u + 1))
      begin
        next_cc[15:8] = wdata;
      end
      // Capture overrides a software write in the same cycle
      if (cap_evt[u])
      begin
        next_cc = ucnt;
      end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        mode[u] <= pcu_pkg::MODE_RESET;
        cc[u] <= pcu_pkg::CC_RESET;
      end
      else
      begin
        mode[u] <= next_mode;
        cc[u] <= next_cc;
      end
    end

    pcu_unit u_unit (
      .clk(clk),
      .rst_n(rst_n),
      .mode(mode[u]),
      .count(ucnt),
      .ten_bit(uten),
      .cc(cc[u]),
      .pin_in(pin_in[u]),
      .match_evt(match_evt[u]),
      .cap_evt(cap_evt[u]),
      .pin_out(pin_out[u]),
      .pin_oe(pin_oe[u])
    );
  end

  // Flag set sources and request enables
  always_comb
  begin
    hw_set = {roll1, match_evt[5] | cap_evt[5], match_evt[4] | cap_evt[4],
      match_evt[3] | cap_evt[3], roll0, match_evt[2] | cap_evt[2],
      match_evt[1] | cap_evt[1], match_evt[0] | cap_evt[0]};
    irq_mask = {ctl1[pcu_pkg::CTL_ROLL_IRQ], mode[5][pcu_pkg::MODE_IRQ_EN],
      mode[4][pcu_pkg::MODE_IRQ_EN], mode[3][pcu_pkg::MODE_IRQ_EN],
      ctl0[pcu_pkg::CTL_ROLL_IRQ], mode[2][pcu_pkg::MODE_IRQ_EN],
      mode[1][pcu_pkg::MODE_IRQ_EN], mode[0][pcu_pkg::MODE_IRQ_EN]};
    flags_wr = wr && addr == pcu_pkg::ADDR_FLAGS;
  end

  pcu_flags u_flags (
    .clk(clk),
    .rst_n(rst_n),
    .hw_set(hw_set),
    .sw_wr(flags_wr),
    .sw_data(wdata),
    .irq_mask(irq_mask),
    .flags(flags),
    .irq(irq)
  );

  // Read mux, unmapped reads give zero
  always_comb
  begin
    next_rdata = 8'h00;
    if (rd)
    begin
      if (addr == pcu_pkg::ADDR_CTL0)
      begin
        next_rdata = ctl0;
      end
      else if (addr == pcu_pkg::ADDR_CTL1)
      begin
        next_rdata = ctl1;
      end
      else if (addr == pcu_pkg::ADDR_FLAGS)
      begin
        next_rdata = flags;
      end
      else if (addr == pcu_pkg::ADDR_CNT_BASE)
      begin
        next_rdata = cnt0[7:0];
      end
      else if (addr == pcu_pkg::ADDR_CNT_BASE + 8'h01)
      begin
        next_rdata = cnt0[15:8];
      end
      else if (addr == pcu_pkg::ADDR_CNT_BASE + 8'h02)
      begin
        next_rdata = cnt1[7:0];
      end
      else if (addr == pcu_pkg::ADDR_CNT_BASE + 8'h03)
      begin
        next_rdata = cnt1[15:8];
      end
      for (int i = 0; i < UNITS; i++)
      begin
        if (addr == pcu_pkg::ADDR_MODE_BASE + 8'(i))
        begin
          next_rdata = mode[i];
        end
        if (addr == pcu_pkg::ADDR_CC_BASE + 8'(2 * i))
        begin
          next_rdata = cc[i][7:0];
        end
        if (addr == pcu_pkg::ADDR_CC_BASE + 8'(2 * i + 1))
        begin
          next_rdata = cc[i][15:8];
        end
      end
    end
  end

  // Read data register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= 8'h00;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end
endmodule // pcu_array
`default_nettype wire

// ---- verilog/pcu_pkg.sv ----
// Constants for the counter array flag, mode and register logic.
// Assumes an 8-bit register port with one-cycle read latency.
package pcu_pkg;
  // Register indices on the 8-bit port
  localparam logic [7:0] ADDR_CTL0 = 8'h00;
  localparam logic [7:0] ADDR_CTL1 = 8'h01;
  localparam logic [7:0] ADDR_FLAGS = 8'h02;
  localparam logic [7:0] ADDR_MODE_BASE = 8'h08;
  localparam logic [7:0] ADDR_CC_BASE = 8'h10;
  localparam logic [7:0] ADDR_CNT_BASE = 8'h20;
  // Counter control fields
  localparam int CTL_ALL_RUN = 7;
  localparam int CTL_RUN = 6;
  localparam int CTL_ROLL_IRQ = 5;
  localparam int CTL_TEN_BIT = 2;
  localparam logic [7:0] CTL0_MASK = 8'he4;
  localparam logic [7:0] CTL1_MASK = 8'h64;
  // Status flag positions
  localparam int FLAG_ROLL1 = 7;
  localparam int FLAG_ROLL0 = 3;
  localparam logic [7:0] ROLL_MASK = 8'h88;
  // Mode fields
  localparam int MODE_IRQ_EN = 7;
  localparam int MODE_COMP_EN = 6;
  localparam int MODE_RISE = 5;
  localparam int MODE_FALL = 4;
  localparam int MODE_MATCH = 3;
  localparam int MODE_TOGGLE = 2;
  localparam int MODE_WAVE_HI = 1;
  localparam int MODE_WAVE_LO = 0;
  localparam logic [1:0] WAVE_OFF = 2'h0;
  localparam logic [1:0] WAVE_FIXED8 = 2'h1;
  localparam logic [1:0] WAVE_PROG8 = 2'h2;
  localparam logic [1:0] WAVE_WIDE = 2'h3;
  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] CC_RESET = 16'h0000;
  // Array shape
  localparam int UNITS = 6;
  localparam int UNITS_PER_CNT = 3;
  localparam logic [9:0] TEN_BIT_TOP = 10'h3ff;
  localparam logic [15:0] SIXTEEN_BIT_TOP = 16'hffff;
endpackage

// ---- verilog/pcu_flags.sv ----
// Status flags of the counter array and the shared interrupt request.
// Assumes set pulses and software writes are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pcu_flags (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [7:0] hw_set, // Event pulses per flag bit
  input wire logic sw_wr, // Software write to flags
  input wire logic [7:0] sw_data, // Written value
  input wire logic [7:0] irq_mask, // Per-flag request enables
  output logic [7:0] flags, // Flag register
  output logic irq // Shared request
);
  logic [7:0] next_flags;
  logic next_irq;
  logic [7:0] after_sw;

  // Software write then hardware set
  always_comb
  begin
    after_sw = flags;
    if (sw_wr)
    begin
      // Zero clears; one sets rollover flags, leaves unit flags
      after_sw = (flags & sw_data) | (sw_data & pcu_pkg::ROLL_MASK);
    end
    next_flags = after_sw | hw_set;
    next_irq = |(next_flags & irq_mask);
  end

  // Flag and request registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags <= pcu_pkg::FLAGS_RESET;
      irq <= 1'b0;
    end
    else
    begin
      flags <= next_flags;
      irq <= next_irq;
    end
  end
endmodule // pcu_flags
`default_nettype wire

// ---- verilog/pcu_unit.sv ----
// One capture/compare unit: mode decode, compare, capture edges, waveform.
// Assumes counter value and pin input synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pcu_unit (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [7:0] mode, // Unit mode register
  input wire logic [15:0] count, // Counter value
  input wire logic ten_bit, // Counter resolution select
  input wire logic [15:0] cc, // Capture/compare value
  input wire logic pin_in, // External pin level
  output logic match_evt, // Match pulse
  output logic cap_evt, // Capture pulse
  output logic pin_out, // Pin drive level
  output logic pin_oe // Pin drive enable
);
  logic pin_prev;
  logic next_pin_prev;
  logic next_match;
  logic next_cap;
  logic next_pin_out;
  logic next_pin_oe;
  logic hit;
  logic [1:0] wave;
  logic wave_lvl;

  // Compare, capture and waveform decode
  always_comb
  begin
    wave = {mode[pcu_pkg::MODE_WAVE_HI], mode[pcu_pkg::MODE_WAVE_LO]};
    hit = mode[pcu_pkg::MODE_COMP_EN] && (count == cc);
    next_pin_prev = pin_in;
    next_match = hit && mode[pcu_pkg::MODE_MATCH];
    next_cap = (mode[pcu_pkg::MODE_RISE] && pin_in && !pin_prev)
      || (mode[pcu_pkg::MODE_FALL] && !pin_in && pin_prev);
    case (wave)
      pcu_pkg::WAVE_FIXED8: wave_lvl = count[7:0] >= cc[7:0];
      pcu_pkg::WAVE_PROG8: wave_lvl = (count[7:0] >= cc[7:0]) && (count[7:0] < cc[15:8]);
      pcu_pkg::WAVE_WIDE: wave_lvl = ten_bit ? (count[9:0] >= cc[9:0]) : (count >= cc);
      default: wave_lvl = 1'b0;
    endcase
    next_pin_out = pin_out;
    if (wave != pcu_pkg::WAVE_OFF)
    begin
      next_pin_out = wave_lvl && mode[pcu_pkg::MODE_COMP_EN];
    end
    else if (hit && mode[pcu_pkg::MODE_TOGGLE])
    begin
      next_pin_out = !pin_out;
    end
    // Idle when all mode bits are clear
    next_pin_oe = (wave != pcu_pkg::WAVE_OFF) || mode[pcu_pkg::MODE_TOGGLE];
  end

  // Unit registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_prev <= 1'b0;
      match_evt <= 1'b0;
      cap_evt <= 1'b0;
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end
    else
    begin
      pin_prev <= next_pin_prev;
      match_evt <= next_match;
      cap_evt <= next_cap;
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
    end
  end
endmodule // pcu_unit
`default_nettype wire

// ---- verilog/pcu_dummy_placeholder_none.sv ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- tb/pcu_array_sva.sv ----
// Checker for the array: register port, shared request, pin enables.
// Sees only the top ports; bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module pcu_array_sva #(
  parameter int UNITS = 6 // Units
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [7:0] addr, // Index
  input wire logic [7:0] wdata, // Data in
  input wire logic wr, // Write
  input wire logic rd, // Read
  input wire logic [7:0] rdata, // Data out
  input wire logic [UNITS-1:0] pin_in, // Pins
  input wire logic [UNITS-1:0] pin_out, // Drive
  input wire logic [UNITS-1:0] pin_oe, // Enables
  input wire logic irq // Request
);
  logic [5:0][7:0] mode, next_mode;
  logic [1:0][7:0] ctl, next_ctl;
  logic [7:0] last, next_last, en;
  logic clean, next_clean, frd, next_frd;
  logic [5:0] idle;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Shadow of mode and control writes, history of flag reads
  always_comb
  begin
    next_mode = mode;
    next_ctl = ctl;
    next_last = last;
    next_clean = clean;
    next_frd = rd && addr == pcu_pkg::ADDR_FLAGS;
    if (wr && addr[7:3] == 5'h01 && addr[2:0] < 3'h6)
      next_mode[addr[2:0]] = wdata;
    if (wr && addr[7:1] == 7'h00)
      next_ctl[addr[0]] = wdata;
    if (frd)
    begin
      next_last = rdata;
      next_clean = 1'b1;
    end
    if (wr && addr == pcu_pkg::ADDR_FLAGS)
      next_clean = 1'b0;
    for (int u = 0; u < 6; u++)
      idle[u] = mode[u] == 8'h00;
  end
  // Register the shadow state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode <= '0;
      ctl <= '0;
      last <= 8'h00;
      clean <= 1'b0;
      frd <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      ctl <= next_ctl;
      last <= next_last;
      clean <= next_clean;
      frd <= next_frd;
    end
  end
  assign en = {ctl[1][5], mode[5][7], mode[4][7], mode[3][7],
    ctl[0][5], mode[2][7], mode[1][7], mode[0][7]};
  function automatic logic mapped(input logic [7:0] a);
    return a < 8'h03 || (a >= 8'h08 && a < 8'h0e) || (a >= 8'h10 && a < 8'h1c)
      || (a >= 8'h20 && a < 8'h24);
  endfunction
  sequence s_wr_rd;
    wr ##1 rd && addr == $past(addr) && (addr < 8'h02 || (addr >= 8'h08 && addr < 8'h0e));
  endsequence
  sequence s_set_roll;
    wr && addr == pcu_pkg::ADDR_FLAGS ##1 rd && addr == pcu_pkg::ADDR_FLAGS;
  endsequence
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_UNMAPPED: assert property (rd && !mapped(addr) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_WR_RB: assert property (s_wr_rd |=> rdata == ($past(addr) == 8'h00 ?
    $past(wdata, 2) & pcu_pkg::CTL0_MASK : $past(addr) == 8'h01 ?
    $past(wdata, 2) & pcu_pkg::CTL1_MASK : $past(wdata, 2)))
    else $error("register readback wrong");
  AST_ROLL_SET: assert property (s_set_roll |=>
    (rdata & $past(wdata, 2) & pcu_pkg::ROLL_MASK) == ($past(wdata, 2) & pcu_pkg::ROLL_MASK))
    else $error("rollover flag not set by write");
  AST_FLAG_STICKY: assert property (frd && clean |-> (rdata & last) == last)
    else $error("flag cleared without a write");
  AST_IRQ_OR: assert property (frd && (rdata & $past(en)) != 8'h00 |-> irq)
    else $error("enabled flag set but no request");
  AST_IRQ_QUIET: assert property (en == 8'h00 && $past(en) == 8'h00 |-> !irq)
    else $error("request with all enables clear");
  AST_IDLE_PIN: assert property ((pin_oe & idle & $past(idle)) == 6'h00)
    else $error("idle unit drives its pin");
endmodule // pcu_array_sva
`default_nettype wire

// ---- tb/pcu_cpu.sv ----
// Software model on the far side: register writes, reads, flag service.
// Assumes strobes sampled on rising clk, read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module pcu_cpu (
  input wire logic clk, // Clock
  output logic [7:0] addr, // Index
  output logic [7:0] wdata, // Data out
  output logic wr, // Write
  output logic rd, // Read
  input wire logic [7:0] rdata // Data in
);
  // Bus quiet at time zero
  initial
  begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Write strobe stays up until the next call or idle
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
  endtask
  task automatic idle;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Read strobe, then data taken in the cycle after it
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    idle();
    #1;
    d = rdata;
  endtask
  // Find pending flags, write zeros at those served
  task automatic serve(input logic [7:0] done_mask);
    logic [7:0] f;
    rreg(pcu_pkg::ADDR_FLAGS, f);
    wreg(pcu_pkg::ADDR_FLAGS, f & ~done_mask);
  endtask
endmodule // pcu_cpu
`default_nettype wire

// ---- tb/pcu_array_bench.sv ----
// Bench for the counter array: registers, flags, request and pins.
// Port driven through the software model, pins driven directly.
`timescale 1ns/1ps
`default_nettype none
module pcu_array_bench;
  logic clk, rst_n, wr, rd, irq;
  logic [7:0] addr, wdata, rdata, v, rnd;
  logic [5:0] ext_pin, pin_in, pin_out, pin_oe;
  logic [1:0] code;
  logic [7:0] regs [10] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d,
    8'h7f};
  int n_mismatch, total_checks, cyc, bit_u;
  integer seed;
  // Wire level: the unit wins where it drives
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_pin);
  pcu_cpu cpu (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  pcu_array #(.UNITS(6)) dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .irq(irq));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    cpu.idle();
    repeat (n) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Level of waveform codes 1 to 3 with count 0 and compare value fc00
  function automatic logic wexp(input logic [1:0] c, input logic ten);
    return c == 2'h3 ? ten : 1'b1;
  endfunction
  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  // Main sequence
  initial
  begin
    seed = 32'hc28b;
    rst_n = 1'b0;
    ext_pin = 6'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    foreach (regs[i])
    begin
      cpu.rreg(regs[i], v);
      chk("reset value", 8'h00, v);
    end
    for (int u = 0; u < 6; u++)
    begin
      rnd = 8'($random(seed));
      cpu.wreg(pcu_pkg::ADDR_MODE_BASE + 8'(u), rnd);
      cpu.rreg(pcu_pkg::ADDR_MODE_BASE + 8'(u), v);
      chk("mode readback", rnd, v);
      cpu.wreg(pcu_pkg::ADDR_MODE_BASE + 8'(u), 8'h00);
    end
    tick(4);
    cpu.serve(8'hff);
    $display("test registers done");
    cpu.wreg(pcu_pkg::ADDR_CTL0, 8'h64);
    tick(1100);
    cpu.rreg(pcu_pkg::ADDR_FLAGS, v);
    chk("rollover0 flag", 8'h08, v);
    chk("irq on rollover", 8'h01, {7'h0, irq});
    cpu.wreg(pcu_pkg::ADDR_CTL0, 8'h00);
    cpu.rreg(pcu_pkg::ADDR_FLAGS, v);
    chk("rollover0 kept", 8'h08, v);
    chk("irq masked", 8'h00, {7'h0, irq});
    cpu.wreg(pcu_pkg::ADDR_FLAGS, 8'h00);
    cpu.rreg(pcu_pkg::ADDR_FLAGS, v);
    chk("rollover cleared", 8'h00, v);
    cpu.wreg(pcu_pkg::ADDR_FLAGS, 8'h88);
    cpu.rreg(pcu_pkg::ADDR_FLAGS, v);
    chk("rollover set by write", 8'h88, v);
    cpu.wreg(pcu_pkg::ADDR_CTL1, 8'h20);
    tick(2);
    #1;
    chk("irq rollover1", 8'h01, {7'h0, irq});
    cpu.wreg(pcu_pkg::ADDR_CTL1, 8'h00);
    cpu.serve(8'hff);
    $display("test rollover done");
    for (int u = 0; u < 6; u++)
    begin
      bit_u = u < 3 ? u : u + 1;
      cpu.wreg(pcu_pkg::ADDR_MODE_BASE + 8'(u), u[0] ? 8'h90 : 8'ha0);
      tick(2);
      ext_pin[u] <= 1'b1;
      tick(3);
      ext_pin[u] <= 1'b0;
      tick(4);
      cpu.rreg(pcu_pkg::ADDR_FLAGS, v);
      chk("capture flag", 8'h01 << bit_u, v);
      chk("irq unit", 8'h01, {7'h0, irq});
      cpu.wreg(pcu_pkg::ADDR_FLAGS, 8'hff);
      cpu.rreg(pcu_pkg::ADDR_FLAGS, v);
      chk("unit flag kept", (8'h01 << bit_u) | 8'h88, v);
      cpu.wreg(pcu_pkg::ADDR_MODE_BASE + 8'(u), 8'h00);
      cpu.serve(8'hff);
    end
    $display("test capture done");
    cpu.wreg(pcu_pkg::ADDR_CC_BASE + 8'h08, 8'h00);
    cpu.wreg(pcu_pkg::ADDR_CC_BASE + 8'h09, 8'hfc);
    for (int k = 0; k < 4; k++)
    begin
      code = k == 3 ? 2'h3 : 2'(k + 1);
      cpu.wreg(pcu_pkg::ADDR_CTL1, k == 3 ? 8'h04 : 8'h00);
      cpu.wreg(pcu_pkg::ADDR_MODE_BASE + 8'h04, 8'h40 | {6'h0, code});
      tick(4);
      #1;
      chk("wave enable", 8'h01, {7'h0, pin_oe[4]});
      chk("wave level", {7'h0, wexp(code, k == 3)}, {7'h0, pin_out[4]});
    end
    cpu.wreg(pcu_pkg::ADDR_MODE_BASE + 8'h04, 8'h00);
    tick(3);
    #1;
    chk("idle pin", 8'h00, {7'h0, pin_oe[4]});
    $display("test waveform done");
    cpu.wreg(pcu_pkg::ADDR_CC_BASE + 8'h06, 8'h10);
    cpu.wreg(pcu_pkg::ADDR_CC_BASE + 8'h07, 8'h00);
    cpu.wreg(pcu_pkg::ADDR_MODE_BASE + 8'h03, 8'h4c);
    // One match flips the level held from earlier random modes
    rnd = {7'h0, ~pin_out[3]};
    cpu.wreg(pcu_pkg::ADDR_CTL1, 8'h40);
    tick(40);
    cpu.wreg(pcu_pkg::ADDR_CTL1, 8'h00);
    cpu.rreg(pcu_pkg::ADDR_FLAGS, v);
    chk("match flag", 8'h10, v);
    chk("toggle level", rnd, {7'h0, pin_out[3]});
    chk("toggle enable", 8'h01, {7'h0, pin_oe[3]});
    chk("irq unit disabled", 8'h00, {7'h0, irq});
    $display("test match done");
    wrap_up();
  end
endmodule // pcu_array_bench
bind pcu_array pcu_array_sva #(.UNITS(UNITS)) u_sva (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .irq(irq));
`default_nettype wire
